/* File: include/acirq_pkg.sv */
// Purpose: Constants and types of the comparator interrupt, status and window registers
// Assumes: APB with 32-bit data, each register in one aligned word
// Notes:   Printed offsets are register indices; byte address is four times the index
package acirq_pkg;

  // Bus geometry
  localparam int ACIRQ_ADDR_W = 8;
  localparam int ACIRQ_DATA_W = 32;

  // Register indices as printed
  localparam logic [7:0] IDX_IRQ_EN_CLR = 8'h04;
  localparam logic [7:0] IDX_IRQ_EN_SET = 8'h05;
  localparam logic [7:0] IDX_IRQ_FLAGS  = 8'h06;
  localparam logic [7:0] IDX_LIVE_STAT  = 8'h08;
  localparam logic [7:0] IDX_RDY_STAT   = 8'h09;
  localparam logic [7:0] IDX_STAT_COPY  = 8'h0a;
  localparam logic [7:0] IDX_WIN_CTRL   = 8'h0c;

  // Byte addresses, four per index
  localparam logic [7:0] ADDR_IRQ_EN_CLR = {IDX_IRQ_EN_CLR[5:0], 2'b00};
  localparam logic [7:0] ADDR_IRQ_EN_SET = {IDX_IRQ_EN_SET[5:0], 2'b00};
  localparam logic [7:0] ADDR_IRQ_FLAGS  = {IDX_IRQ_FLAGS[5:0], 2'b00};
  localparam logic [7:0] ADDR_LIVE_STAT  = {IDX_LIVE_STAT[5:0], 2'b00};
  localparam logic [7:0] ADDR_RDY_STAT   = {IDX_RDY_STAT[5:0], 2'b00};
  localparam logic [7:0] ADDR_STAT_COPY  = {IDX_STAT_COPY[5:0], 2'b00};
  localparam logic [7:0] ADDR_WIN_CTRL   = {IDX_WIN_CTRL[5:0], 2'b00};

  // Field positions
  localparam int BIT_WIN_IRQ   = 4;
  localparam int BIT_WSTATE_LO = 4;
  localparam int BIT_SYNC_BUSY = 7;
  localparam int BIT_WIN_EN    = 0;
  localparam int BIT_WCOND_LO  = 1;

  // Values after reset
  localparam logic [7:0] RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_WIN_CTRL  = 8'h00;

  // Window position codes, plus the outside condition code
  localparam logic [1:0] WPOS_ABOVE  = 2'h0;
  localparam logic [1:0] WPOS_INSIDE = 2'h1;
  localparam logic [1:0] WPOS_BELOW  = 2'h2;
  localparam logic [1:0] WSEL_OUTSIDE = 2'h3;

  // Comparator interrupt condition codes
  localparam logic [1:0] CSEL_TOGGLE  = 2'h0;
  localparam logic [1:0] CSEL_RISING  = 2'h1;
  localparam logic [1:0] CSEL_FALLING = 2'h2;
  localparam logic [1:0] CSEL_EOC     = 2'h3;

  // Signals coming from the comparator core domain
  typedef struct packed {
    logic       wctrl_ack; // Toggle echo of window control request
    logic [1:0] busy;      // Comparison in progress
    logic [1:0] ready;     // Output ready
    logic [1:0] level;     // Comparator output level
  } acirq_core_t;

  // Per-comparator configuration held elsewhere
  typedef struct packed {
    logic       enable;
    logic       single;
    logic [1:0] cond;
  } acirq_cmp_cfg_t;

  // Window control contents
  typedef struct packed {
    logic [1:0] cond;
    logic       pair_en;
  } acirq_wctrl_t;

  // Status copy read sequencer, Gray along the path
  typedef enum logic [1:0] {
    STC_IDLE   = 2'b00,
    STC_LAUNCH = 2'b01,
    STC_WAIT   = 2'b11,
    STC_DONE   = 2'b10
  } acirq_stc_state_t;

endpackage

/* File: hw/acirq_sync2.sv */
// Purpose: Two flip-flop synchroniser for a bundle of level signals
// Assumes: Each bit changes slowly against sys_clk
// Notes:   Bits are not coherent with each other across the crossing
`timescale 1ns/1ps
module acirq_sync2 #(
  parameter int W = 7
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta; // First stage, read only by the second

  // Plain double register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // acirq_sync2

/* File: hw/acirq_regs.sv */
// Purpose: APB register bank for comparator interrupts, status and window control
// Assumes: Comparator core signals are asynchronous; config inputs are on sys_clk
// Notes:   Status copy reads stall the bus until comparisons settle
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module acirq_regs #(
  parameter logic [1:0] CMP_PRESENT = 2'b11 // Implemented comparators
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [acirq_pkg::ACIRQ_ADDR_W-1:0] paddr,
  input  wire logic [acirq_pkg::ACIRQ_DATA_W-1:0] pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic                                 pready,
  output logic [acirq_pkg::ACIRQ_DATA_W-1:0]   prdata,
  output logic                                 pslverr,
  input  wire acirq_pkg::acirq_core_t          core_async,
  input  wire acirq_pkg::acirq_cmp_cfg_t [1:0] cmp_cfg,
  input  wire logic                            write_lock,
  input  wire logic [1:0]                      sw_start,
  output logic [1:0]                           cmp_start,
  output acirq_pkg::acirq_wctrl_t              wctrl_out,
  output logic                                 wctrl_req,
  output logic                                 irq
);

  // Window position from the two levels: comp0 upper, comp1 lower threshold
  function automatic logic [1:0] win_pos(input logic [1:0] lv);
    if (lv[0]) begin
      win_pos = acirq_pkg::WPOS_ABOVE;
    end else if (!lv[1]) begin
      win_pos = acirq_pkg::WPOS_BELOW;
    end else begin
      win_pos = acirq_pkg::WPOS_INSIDE;
    end
  endfunction

  // Does a window position satisfy the selected condition
  function automatic logic win_match(input logic [1:0] cond, input logic [1:0] pos);
    if (cond == acirq_pkg::WSEL_OUTSIDE) begin
      win_match = (pos != acirq_pkg::WPOS_INSIDE);
    end else begin
      win_match = (pos == cond);
    end
  endfunction

  // Comparator event by selected condition
  function automatic logic cmp_hit(input logic [1:0] cond, input logic prev,
                                   input logic cur, input logic eoc);
    case (cond)
      acirq_pkg::CSEL_TOGGLE:  cmp_hit = prev ^ cur;
      acirq_pkg::CSEL_RISING:  cmp_hit = ~prev & cur;
      acirq_pkg::CSEL_FALLING: cmp_hit = prev & ~cur;
      default:                 cmp_hit = eoc;
    endcase
  endfunction

  // Status byte shared by live status and its copy
  function automatic logic [7:0] status_byte(input logic [1:0] ws, input logic [1:0] lv);
    logic [7:0] b;
    b = 8'h00;
    b[acirq_pkg::BIT_WSTATE_LO +: 2] = ws;
    b[1:0] = lv;
    status_byte = b;
  endfunction

  // Synchronised core view and its previous sample
  logic [6:0]             core_vec;   // Raw synchroniser output
  acirq_pkg::acirq_core_t core_s;     // Synchronised core signals
  logic [1:0]             level_q;    // Previous levels
  logic [1:0]             busy_q;     // Previous busy
  logic                   win_valid_q; // Window was valid last cycle

  // Register state
  logic                          en_win;     // Window interrupt enable
  logic [1:0]                    en_cmp;     // Comparator interrupt enables
  logic                          flag_win;   // Window interrupt flag
  logic [1:0]                    flag_cmp;   // Comparator interrupt flags
  acirq_pkg::acirq_wctrl_t       wctrl;      // Window control
  logic [1:0]                    pend;       // Started, end not yet seen
  acirq_pkg::acirq_stc_state_t   stc_state;  // Status copy sequencer
  acirq_pkg::acirq_stc_state_t   next_stc_state;

  // Core signals cross through two flops before use
  acirq_sync2 #(
    .W (7)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (core_async),
    .q       (core_vec)
  );
  assign core_s = acirq_pkg::acirq_core_t'(core_vec);

  // Bus phase decode
  wire setup  = psel & ~penable;
  wire access = psel & penable;

  // Address decode
  wire sel_clr  = (paddr == acirq_pkg::ADDR_IRQ_EN_CLR);
  wire sel_set  = (paddr == acirq_pkg::ADDR_IRQ_EN_SET);
  wire sel_flg  = (paddr == acirq_pkg::ADDR_IRQ_FLAGS);
  wire sel_live = (paddr == acirq_pkg::ADDR_LIVE_STAT);
  wire sel_rdy  = (paddr == acirq_pkg::ADDR_RDY_STAT);
  wire sel_stc  = (paddr == acirq_pkg::ADDR_STAT_COPY);
  wire sel_win  = (paddr == acirq_pkg::ADDR_WIN_CTRL);
  wire mapped   = sel_clr | sel_set | sel_flg | sel_live | sel_rdy | sel_stc | sel_win;

  // Lock covers the protected registers only
  wire locked_wr = pwrite & write_lock & (sel_clr | sel_set | sel_win);

  // Domain transfer still in flight
  wire sync_busy = wctrl_req ^ core_s.wctrl_ack;

  // Bus answer
  wire stc_rd   = sel_stc & ~pwrite;
  wire win_hold = sel_win & pwrite & ~write_lock & sync_busy;
  // A new window write waits so the toggle never laps the echo
  assign pready  = stc_rd ? (stc_state == acirq_pkg::STC_DONE) : ~win_hold;
  assign pslverr = access & pready & (~mapped | locked_wr);

  // Write strobes, effective only at the completing edge
  wire wr_ok  = access & pwrite & pready & pstrb[0] & ~locked_wr;
  wire wr_clr = wr_ok & sel_clr;
  wire wr_set = wr_ok & sel_set;
  wire wr_flg = wr_ok & sel_flg;
  wire wr_win = wr_ok & sel_win;

  // Write masks in the common bit layout
  wire [1:0] wd_cmp = pwdata[1:0];
  wire       wd_win = pwdata[acirq_pkg::BIT_WIN_IRQ];

  // Comparator readiness and state
  wire [1:0] rdy   = core_s.ready & CMP_PRESENT;
  wire [1:0] lvl   = core_s.level & CMP_PRESENT;
  wire [1:0] busy_fall = busy_q & ~core_s.busy;

  // Comparator events, gated by readiness except end of comparison
  logic [1:0] cmp_ev;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // End of comparison counts only in single-shot mode
      cmp_ev[i] = CMP_PRESENT[i] & cmp_hit(cmp_cfg[i].cond, level_q[i],
                  core_s.level[i], busy_fall[i] & cmp_cfg[i].single)
                  & (core_s.ready[i] | (cmp_cfg[i].cond == acirq_pkg::CSEL_EOC));
    end
  end

  // Window decoding
  wire       win_valid = wctrl.pair_en & (&rdy);
  wire [1:0] pos_cur   = win_pos(core_s.level);
  wire [1:0] pos_prev  = win_pos(level_q);
  wire [1:0] wstate    = win_valid ? pos_cur : acirq_pkg::WPOS_ABOVE;
  // Event on entering the selected region, not while staying in it
  wire win_ev = win_valid & win_match(wctrl.cond, pos_cur)
              & ~(win_valid_q & win_match(wctrl.cond, pos_prev));

  // Next interrupt enables, one shared state behind both registers
  wire [1:0] clr_cmp = wr_clr ? wd_cmp : 2'b00;
  wire [1:0] set_cmp = wr_set ? wd_cmp : 2'b00;
  wire [1:0] next_en_cmp = (en_cmp & ~clr_cmp) | set_cmp;
  wire next_en_win = (en_win & ~(wr_clr & wd_win)) | (wr_set & wd_win);

  // Next flags: a fresh event wins over a clear in the same cycle
  wire [1:0] next_flag_cmp = ((flag_cmp & ~(wr_flg ? wd_cmp : 2'b00)) | cmp_ev)
                           & CMP_PRESENT;
  wire next_flag_win = (flag_win & ~(wr_flg & wd_win)) | win_ev;

  // Interrupt request
  assign irq = (flag_win & en_win) | (|(flag_cmp & en_cmp));

  // Readback bytes
  wire [7:0] en_byte   = {3'b000, en_win, 2'b00, en_cmp};
  wire [7:0] flg_byte  = {3'b000, flag_win, 2'b00, flag_cmp};
  wire [7:0] stat_byte = status_byte(wstate, lvl);
  wire [7:0] rdy_byte  = {sync_busy, 5'b00000, rdy};
  wire [7:0] win_byte  = {5'b00000, wctrl.cond, wctrl.pair_en};

  // Read select chain; unmapped reads give zero
  wire [7:0] rd_byte = (sel_clr | sel_set) ? en_byte :
                       sel_flg  ? flg_byte  :
                       sel_live ? stat_byte :
                       sel_rdy  ? rdy_byte  :
                       sel_win  ? win_byte  : 8'h00;

  // Single-shot launching
  wire [1:0] shot_ok = {cmp_cfg[1].single & cmp_cfg[1].enable,
                        cmp_cfg[0].single & cmp_cfg[0].enable} & CMP_PRESENT;
  wire [1:0] sw_go   = sw_start & shot_ok;
  // Busy or already launched comparators are left alone
  wire [1:0] stc_go  = shot_ok & ~core_s.busy & ~pend;
  wire [1:0] next_start = sw_go
                        | ((stc_state == acirq_pkg::STC_LAUNCH) ? stc_go : 2'b00);

  // Every enabled comparator settled and nothing outstanding
  wire [1:0] en_mask = {cmp_cfg[1].enable, cmp_cfg[0].enable} & CMP_PRESENT;
  wire all_done = ~(|pend) & ~(|(en_mask & (~rdy | core_s.busy)));

  // Sequencer for the stalling status copy read
  always_comb begin
    next_stc_state = stc_state;
    case (stc_state)
      acirq_pkg::STC_IDLE: begin
        // Launch once per read, at the setup cycle
        if (setup & stc_rd) begin
          next_stc_state = acirq_pkg::STC_LAUNCH;
        end
      end
      acirq_pkg::STC_LAUNCH: begin
        next_stc_state = acirq_pkg::STC_WAIT;
      end
      acirq_pkg::STC_WAIT: begin
        if (all_done) begin
          next_stc_state = acirq_pkg::STC_DONE;
        end
      end
      default: begin
        // Answer is given while in this state
        if (access) begin
          next_stc_state = acirq_pkg::STC_IDLE;
        end
      end
    endcase
  end

  // Sequencer state and start pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stc_state <= acirq_pkg::STC_IDLE;
      cmp_start <= 2'b00;
    end else begin
      stc_state <= next_stc_state;
      cmp_start <= next_start;
    end
  end

  // Outstanding launches end when the core drops busy or the comparator stops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 2'b00;
    end else begin
      pend <= (pend & ~busy_fall & en_mask) | next_start;
    end
  end

  // Previous samples for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q     <= 2'b00;
      busy_q      <= 2'b00;
      win_valid_q <= 1'b0;
    end else begin
      level_q     <= core_s.level;
      busy_q      <= core_s.busy;
      win_valid_q <= win_valid;
    end
  end

  // Interrupt enables and flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_win   <= acirq_pkg::RST_IRQ_EN[acirq_pkg::BIT_WIN_IRQ];
      en_cmp   <= acirq_pkg::RST_IRQ_EN[1:0];
      flag_win <= acirq_pkg::RST_IRQ_FLAGS[acirq_pkg::BIT_WIN_IRQ];
      flag_cmp <= acirq_pkg::RST_IRQ_FLAGS[1:0];
    end else begin
      en_win   <= next_en_win;
      en_cmp   <= next_en_cmp;
      flag_win <= next_flag_win;
      flag_cmp <= next_flag_cmp;
    end
  end

  // Window control and its crossing toggle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wctrl     <= acirq_pkg::RST_WIN_CTRL[2:0];
      wctrl_req <= 1'b0;
    end else if (wr_win) begin
      wctrl.pair_en <= pwdata[acirq_pkg::BIT_WIN_EN];
      wctrl.cond    <= pwdata[acirq_pkg::BIT_WCOND_LO +: 2];
      wctrl_req     <= ~wctrl_req;
    end
  end

  // Core copy held stable while the toggle crosses
  assign wctrl_out = wctrl;

  // Read data register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (setup & ~pwrite & ~sel_stc) begin
      prdata <= {24'h000000, rd_byte};
    end else if ((stc_state == acirq_pkg::STC_WAIT) & all_done) begin
      // Settled values, same layout as live status
      prdata <= {24'h000000, stat_byte};
    end
  end

endmodule // acirq_regs

/* File: verification/acirq_core_model.sv */
// Purpose: Comparator core model behind the register bank
// Assumes: Starts arrive as one-cycle pulses on sys_clk
// Notes:   A comparison stays busy eight cycles, long enough to cross sync
`timescale 1ns/1ps
module acirq_core_model (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic [1:0]         cmp_start,
  input  wire logic [1:0]         cmp_on,
  input  wire logic [1:0]         lvl,
  input  wire logic               wctrl_req,
  output acirq_pkg::acirq_core_t  core
);
  logic [2:0] echo;    // Echo delay of window control toggles
  logic [3:0] cnt [2]; // Busy countdown per comparator
  // Echo and busy timers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      echo <= 3'h0;
      cnt <= '{default: 4'h0};
    end else begin
      echo <= {echo[1:0], wctrl_req};
      for (int i = 0; i < 2; i++) begin
        if (cmp_start[i]) cnt[i] <= 4'h8;
        else if (cnt[i] != 4'h0) cnt[i] <= cnt[i] - 4'h1;
      end
    end
  end
  // A level that is not ready shows the inverse, never a stale value
  always_comb begin
    core.wctrl_ack = echo[2];
    for (int i = 0; i < 2; i++) begin
      core.busy[i] = cnt[i] != 4'h0;
      core.ready[i] = cmp_on[i] && cnt[i] == 4'h0;
      core.level[i] = core.ready[i] ? lvl[i] : ~lvl[i];
    end
  end
endmodule // acirq_core_model

/* File: verification/acirq_regs_monitor.sv */
// Purpose: Port checks on the comparator register bank
// Assumes: Core answers every start within a few dozen cycles
// Notes:   Bound into every instance of the bank
`timescale 1ns/1ps
module acirq_regs_monitor #(
  parameter logic [1:0] CMP_PRESENT = 2'b11 // Implemented comparators
) (
  input wire logic                                sys_clk,
  input wire logic                                rst_n,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [acirq_pkg::ACIRQ_ADDR_W-1:0]  paddr,
  input wire logic [acirq_pkg::ACIRQ_DATA_W-1:0]  pwdata,
  input wire logic [3:0]                          pstrb,
  input wire logic                                pready,
  input wire logic [acirq_pkg::ACIRQ_DATA_W-1:0]  prdata,
  input wire logic                                pslverr,
  input wire acirq_pkg::acirq_core_t              core_async,
  input wire acirq_pkg::acirq_cmp_cfg_t [1:0]     cmp_cfg,
  input wire logic                                write_lock,
  input wire logic [1:0]                          sw_start,
  input wire logic [1:0]                          cmp_start,
  input wire acirq_pkg::acirq_wctrl_t             wctrl_out,
  input wire logic                                wctrl_req,
  input wire logic                                irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire wr = psel && penable && pready && pwrite && pstrb[0]; // Accepted write
  wire rc = psel && !penable && !pwrite && paddr == 8'h28;   // Copy read setup
  wire [1:0] arm = {cmp_cfg[1].single && cmp_cfg[1].enable,
                    cmp_cfg[0].single && cmp_cfg[0].enable}; // Single-shot armed
  a_clear_all_irq: assert property (
    wr && !write_lock && paddr == 8'h10 && pwdata[4:0] == 5'h13 |=> !irq)
    else $error("irq high with all enables cleared");
  a_win_write: assert property (
    wr && !write_lock && paddr == 8'h30 |=> wctrl_req != $past(wctrl_req)
      && wctrl_out == $past(pwdata[2:0]))
    else $error("window control write not carried");
  a_win_locked: assert property (
    wr && write_lock && paddr == 8'h30 |-> pslverr ##1 $stable(wctrl_req))
    else $error("locked window write took effect");
  a_copy_stall: assert property (
    rc |=> !pready [*2]) else $error("copy read not stalled");
  a_copy_bound: assert property (
    rc |=> ##[2:60] pready) else $error("copy read never answered");
  a_start_armed: assert property (
    (cmp_start & ~$past(arm)) == 2'b00) else $error("start while not armed");
  a_no_restart: assert property (
    core_async.busy[0] && $past(core_async.busy[0], 4) |-> !cmp_start[0])
    else $error("start on busy comparator");
  a_ro_write: assert property (
    psel && penable && pwrite && paddr inside {8'h20, 8'h24, 8'h28}
      |-> pready && !pslverr) else $error("status write answered wrongly");
endmodule // acirq_regs_monitor

bind acirq_regs acirq_regs_monitor #(.CMP_PRESENT(CMP_PRESENT)) u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .core_async(core_async), .cmp_cfg(cmp_cfg), .write_lock(write_lock),
  .sw_start(sw_start), .cmp_start(cmp_start), .wctrl_out(wctrl_out),
  .wctrl_req(wctrl_req), .irq(irq));

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the comparator register bank
// Assumes: Core model echoes toggles and runs single-shot comparisons
// Notes:   Fixed waits cover the two-flop input synchroniser and the toggle echo delay
`timescale 1ns/1ps
module testbench;
  `define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_mismatch++; \
    $display("ERROR %0t: got %h want %h", $time, (g), (x)); end end
  logic                            sys_clk = 1'b0;
  logic                            rst_n = 1'b0;
  logic                            psel = 1'b0;
  logic                            penable = 1'b0;
  logic                            pwrite = 1'b0;
  logic [7:0]                      paddr = 8'h00;
  logic [31:0]                     pwdata = 32'h0;
  logic [3:0]                      pstrb = 4'hf;
  logic                            pready, pslverr, wctrl_req, irq;
  logic [31:0]                     prdata;
  logic [1:0]                      cmp_start;
  logic [1:0]                      sw_start = 2'h0;
  logic [1:0]                      lvl = 2'h0; // Analog side, bit set = above
  logic                            write_lock = 1'b0;
  acirq_pkg::acirq_cmp_cfg_t [1:0] cfg = '0;
  acirq_pkg::acirq_core_t          core;
  acirq_pkg::acirq_wctrl_t         wctrl_out;
  logic [7:0]                      ra [7] = '{8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h30};
  int                              n_mismatch = 0;
  int                              comparisons = 0;
  int                              n_start = 0; // Starts seen on comparator 0
  int                              s0;
  logic [7:0]                      r;
  logic                            e;
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (cmp_start[0] === 1'b1) n_start++;
  acirq_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .core_async(core), .cmp_cfg(cfg),
    .write_lock(write_lock), .sw_start(sw_start), .cmp_start(cmp_start),
    .wctrl_out(wctrl_out), .wctrl_req(wctrl_req), .irq(irq));
  acirq_core_model u_core (.sys_clk(sys_clk), .rst_n(rst_n), .cmp_start(cmp_start),
    .cmp_on({cfg[1].enable, cfg[0].enable}), .lvl(lvl), .wctrl_req(wctrl_req), .core(core));
  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One transfer, then an idle cycle so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 300);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 300) begin
      n_mismatch++;
      report_and_stop();
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
    apb(1'b0, a, 8'h00);
    `CHK(r & m, x)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Comparator 0 flag after a rise, then after a fall
  task automatic edge_chk(input logic [1:0] c, input logic [1:0] ex);
    cfg[0] <= {1'b1, 1'b0, c};
    lvl[0] <= 1'b0;
    tick(6);
    wr(8'h18, 8'h13);
    lvl[0] <= 1'b1;
    tick(6);
    rd(8'h18, {7'h0, ex[1]}, 8'h01);
    wr(8'h18, 8'h01);
    lvl[0] <= 1'b0;
    tick(6);
    rd(8'h18, {7'h0, ex[0]}, 8'h01);
  endtask
  // Window flag on entering the selected region, and the reported state
  task automatic win_chk(input logic [1:0] c, input logic [1:0] s, input logic [1:0] t,
                         input logic [7:0] live);
    lvl <= s;
    wr(8'h30, {5'h0, c, 1'b1});
    `CHK(wctrl_out, {c, 1'b1})
    rd(8'h24, 8'h83);
    tick(12);
    rd(8'h24, 8'h03);
    wr(8'h18, 8'h13);
    lvl <= t;
    tick(6);
    rd(8'h18, 8'h10, 8'h10);
    rd(8'h20, live);
    rd(8'h28, live);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Level bits mean nothing while no comparator is ready, so mask them
    foreach (ra[i]) begin
      rd(ra[i], 8'h00, (i == 3 || i == 5) ? 8'hfc : 8'hff);
    end
    apb(1'b0, 8'h3c, 8'h00);
    `CHK({r, e}, 9'h001)
    $display("test reset done");
    wr(8'h14, 8'h13);
    rd(8'h10, 8'h13);
    wr(8'h10, 8'h01);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h12);
    wr(8'h10, 8'h10);
    rd(8'h10, 8'h02);
    $display("test enables done");
    edge_chk(acirq_pkg::CSEL_TOGGLE, 2'b11);
    edge_chk(acirq_pkg::CSEL_RISING, 2'b10);
    edge_chk(acirq_pkg::CSEL_FALLING, 2'b01);
    `CHK(irq, 1'b0)
    wr(8'h14, 8'h01);
    `CHK(irq, 1'b1)
    wr(8'h18, 8'h01);
    `CHK(irq, 1'b0)
    wr(8'h10, 8'h13);
    $display("test flags done");
    cfg <= 8'h88;
    win_chk(2'h0, 2'b00, 2'b01, 8'h01);
    win_chk(2'h1, 2'b00, 2'b10, 8'h12);
    win_chk(2'h2, 2'b10, 2'b00, 8'h20);
    win_chk(2'h3, 2'b10, 2'b11, 8'h03);
    lvl <= 2'b10;
    wr(8'h30, 8'h00);
    // Second write lands while the first is still crossing, so it stalls
    wr(8'h30, 8'h00);
    rd(8'h24, 8'h83);
    wr(8'h20, 8'hff);
    tick(12);
    rd(8'h20, 8'h02);
    write_lock <= 1'b1;
    wr(8'h30, 8'h07);
    `CHK(e, 1'b1)
    wr(8'h14, 8'h13);
    `CHK(e, 1'b1)
    write_lock <= 1'b0;
    rd(8'h30, 8'h00);
    rd(8'h10, 8'h00);
    $display("test window done");
    cfg <= 8'h8f;
    tick(8);
    wr(8'h18, 8'h13);
    s0 = n_start;
    rd(8'h28, 8'h02);
    `CHK(n_start - s0, 1)
    rd(8'h18, 8'h01, 8'h01);
    sw_start <= 2'b01;
    @(posedge sys_clk);
    sw_start <= 2'b00;
    tick(5);
    rd(8'h28, 8'h02);
    `CHK(n_start - s0, 2)
    cfg <= 8'h8b;
    tick(2);
    sw_start <= 2'b01;
    @(posedge sys_clk);
    sw_start <= 2'b00;
    tick(12);
    `CHK(n_start - s0, 2)
    $display("test single shot done");
    report_and_stop();
  end
endmodule // testbench
